// [design/sep_pkg.sv]
// sep_pkg: constants and types of the status/protection command logic
// assumes: a 250 MHz core clock, spi pins sampled by that clock
package sep_pkg;

  // ==========================================================
  // opcodes, msb first on the wire
  localparam logic [7:0] SEP_OP_SET_LATCH = 8'h06; // set write latch
  localparam logic [7:0] SEP_OP_CLR_LATCH = 8'h04; // clear write latch
  localparam logic [7:0] SEP_OP_RD_STAT   = 8'h05; // status read
  localparam logic [7:0] SEP_OP_WR_STAT   = 8'h01; // status write

  // ==========================================================
  // status byte field positions
  localparam int SEP_BIT_LOCK = 7; // status lock bit
  localparam int SEP_BIT_BPH  = 3; // block protect high
  localparam int SEP_BIT_BPL  = 2; // block protect low

  // ==========================================================
  // reset values (delivered state: nothing locked or protected)
  localparam logic       SEP_RST_LOCK = 1'b0;
  localparam logic [1:0] SEP_RST_BP   = 2'b00;
  localparam logic       SEP_RST_LATCH = 1'b0;

  // ==========================================================
  // protected region bases within the 19-bit array space
  localparam logic [18:0] SEP_QTR_BASE  = 19'h60000; // upper quarter
  localparam logic [18:0] SEP_HALF_BASE = 19'h40000; // upper half

  // ==========================================================
  // timing
  localparam int unsigned SEP_CLK_PERIOD_NS = 4;       // core clock
  localparam int unsigned SEP_WRITE_NS      = 5000000; // self-timed write

  // status byte as seen on the wire
  typedef struct packed {
    logic       lock; // b7
    logic [2:0] zero; // b6..b4, always 0
    logic [1:0] bp;   // b3..b2
    logic       latch; // b1
    logic       busy; // b0
  } sep_status_t;

  // raw pin group
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic mosi;
    logic wp_n;
  } sep_pins_t;

  // command decoder states
  typedef enum logic [2:0] {
    ST_OPCODE,    // deselected or taking opcode bits
    ST_HOLDOFF,   // ignore input until deselect
    ST_STAT_OUT,  // shifting the status byte out
    ST_STAT_DATA, // taking the status data byte
    ST_STAT_FULL  // data complete, waiting for deselect
  } sep_state_t;

endpackage

// [design/sep_status_ctrl.sv]
// sep_status_ctrl: spi status/protection command logic of a serial eeprom
// assumes: spi pins are asynchronous; array logic shares core_clk
//
// Contract
// R01: host sends set-latch before every write
// R02: after set-latch opcode, ignore until deselect
// R03: set-latch command sets write latch
// R04: latch cleared by clear command, write end
// R05: clear-latch acts at chip select rise
// R06: status read accepted at any time
// R07: status read repeats live byte while selected
// R08: host should poll busy before new commands
// R09: busy reads one during self-timed write
// R10: latch zero: writes decoded, never executed
// R11: protect bits only via status write
// R12: lock plus low pin rejects status write
// R13: protect bits change only outside hardware mode
// R14: status write needs latch set beforehand
// R15: deselect exactly after eighth data bit
// R16: byte-boundary deselect starts timed write
// R17: new protect values apply after write
// R18: bits six to four read zero
// R19: lock zero: writable whatever pin level
// R20: lock one, pin high: still writable
// R21: hardware mode follows lock and pin
// R22: only selected region rejects array writes
// R23: all bytes most significant bit first
// R24: fixed opcode encodings
// R25: protect codes map to address ranges
// R26: sample on rise, shift out on fall
`timescale 1ns/1ps
`default_nettype none
module sep_status_ctrl
  import sep_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES =
    (sep_pkg::SEP_WRITE_NS + sep_pkg::SEP_CLK_PERIOD_NS - 1)
    / sep_pkg::SEP_CLK_PERIOD_NS
) (
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  input  wire logic                 spi_sclk,
  input  wire logic                 spi_cs_n,
  input  wire logic                 spi_mosi,
  input  wire logic                 wp_n,
  output logic                      spi_miso,
  output logic                      spi_miso_oe,
  input  wire logic                 array_wr_req,
  input  wire logic [18:0]          array_wr_addr,
  output logic                      array_wr_accept,
  output logic                      addr_protected_ff,
  output sep_pkg::sep_status_t      status_byte
);
  import sep_pkg::*;

  // ==========================================================
  // pin synchronisers
  sep_pins_t  pins_s1_ff;  // first stage, read only by second
  sep_pins_t  pins_s2_ff;  // safe copy
  logic       sclk_d_ff;   // previous sclk for edges
  logic       cs_d_ff;     // previous cs for edges

  // two flops per pin; the edge finders read only the second stage
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pins_s1_ff <= '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0, wp_n: 1'b1};
      pins_s2_ff <= '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0, wp_n: 1'b1};
      sclk_d_ff  <= 1'b0;
      cs_d_ff    <= 1'b1;
    end else begin
      pins_s1_ff <= '{sclk: spi_sclk, cs_n: spi_cs_n,
                      mosi: spi_mosi, wp_n: wp_n};
      pins_s2_ff <= pins_s1_ff;
      sclk_d_ff  <= pins_s2_ff.sclk;
      cs_d_ff    <= pins_s2_ff.cs_n;
    end
  end

  logic sclk_rise;  // sample point
  logic sclk_fall;  // shift-out point
  logic cs_rise;    // deselect, where commands act
  logic selected;   // chip select low
  assign sclk_rise = pins_s2_ff.sclk & ~sclk_d_ff;
  assign sclk_fall = ~pins_s2_ff.sclk & sclk_d_ff;
  assign cs_rise   = pins_s2_ff.cs_n & ~cs_d_ff;
  assign selected  = ~pins_s2_ff.cs_n;

  // ==========================================================
  // command decoder
  sep_state_t  state_ff;   // decoder state
  logic [2:0]  bit_cnt_ff; // bit within current byte
  logic [7:0]  sh_in_ff;   // input shifter
  logic [7:0]  cmd_ff;     // opcode waiting for deselect
  logic [7:0]  wr_data_ff; // status write data byte
  logic [7:0]  byte_in;    // byte completed by this edge
  logic        lock_ff;    // status lock bit
  logic [1:0]  bp_ff;      // block protect bits
  logic        latch_ff;   // write enable latch
  logic        busy_ff;    // self-timed write running

  assign byte_in = {sh_in_ff[6:0], pins_s2_ff.mosi}; // R23

  // one byte frame per command; deselect always restarts it
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_ff   <= ST_OPCODE;
      bit_cnt_ff <= 3'h0;
      sh_in_ff   <= 8'h00;
      cmd_ff     <= 8'h00;
      wr_data_ff <= 8'h00;
    end else if (!selected) begin
      state_ff   <= ST_OPCODE;
      bit_cnt_ff <= 3'h0;
    end else if (sclk_rise) begin // R26
      sh_in_ff   <= byte_in;
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
      case (state_ff)
        ST_OPCODE: begin
          if (bit_cnt_ff == 3'h7) begin
            // only status read may enter a running write
            if (busy_ff && byte_in != SEP_OP_RD_STAT) begin // R06
              state_ff <= ST_HOLDOFF;
              cmd_ff   <= 8'h00;
            end else if (byte_in == SEP_OP_RD_STAT) begin // R24
              state_ff <= ST_STAT_OUT;
            end else if (byte_in == SEP_OP_WR_STAT) begin
              state_ff <= ST_STAT_DATA;
            end else begin
              // set/clear latch wait here; unknown opcodes too
              state_ff <= ST_HOLDOFF; // R02
              cmd_ff   <= byte_in;
            end
          end
        end
        ST_STAT_DATA: begin
          if (bit_cnt_ff == 3'h7) begin
            state_ff   <= ST_STAT_FULL;
            wr_data_ff <= byte_in;
          end
        end
        ST_STAT_FULL: begin
          // a ninth bit spoils the byte boundary
          state_ff <= ST_HOLDOFF; // R15
          cmd_ff   <= 8'h00;
        end
        default: begin
          state_ff <= state_ff; // holdoff and read ignore input
        end
      endcase
    end
  end

  // ==========================================================
  // execution at deselect
  logic hw_mode;   // hardware protected mode
  logic set_go;    // set-latch executes
  logic clr_go;    // clear-latch executes
  logic stat_try;  // status write ended on a boundary
  logic stat_go;   // status write accepted
  logic arr_prot;  // requested address in protected region
  logic arr_go;    // array write accepted
  logic wr_done;   // last cycle of self-timed write

  assign hw_mode  = lock_ff & ~pins_s2_ff.wp_n; // R21 R19 R20
  assign set_go   = cs_rise && state_ff == ST_HOLDOFF
                    && cmd_ff == SEP_OP_SET_LATCH;
  assign clr_go   = cs_rise && state_ff == ST_HOLDOFF
                    && cmd_ff == SEP_OP_CLR_LATCH; // R05
  assign stat_try = cs_rise && state_ff == ST_STAT_FULL; // R16
  // latch and mode gate the write; pin level alone never does
  assign stat_go  = stat_try & latch_ff & ~hw_mode & ~busy_ff; // R12 R13
  assign arr_go   = array_wr_req & latch_ff & ~busy_ff
                    & ~arr_prot & ~stat_go; // R10
  assign array_wr_accept = arr_go;

  // region check against the current protect code
  always_comb begin
    case (bp_ff) // R25
      2'b01:   arr_prot = array_wr_addr >= SEP_QTR_BASE;
      2'b10:   arr_prot = array_wr_addr >= SEP_HALF_BASE;
      2'b11:   arr_prot = 1'b1;
      default: arr_prot = 1'b0; // R22
    endcase
  end

  // registered copy of the region check
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      addr_protected_ff <= 1'b0;
    end else begin
      addr_protected_ff <= arr_prot;
    end
  end

  // ==========================================================
  // self-timed write
  logic [31:0] prog_cnt_ff; // cycles spent in the write
  assign wr_done = busy_ff && prog_cnt_ff == WRITE_CYCLES - 1;

  // busy stays up for the whole programming time
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      busy_ff     <= 1'b0;
      prog_cnt_ff <= 32'h0;
    end else if (stat_go || arr_go) begin
      busy_ff     <= 1'b1; // R09
      prog_cnt_ff <= 32'h0;
    end else if (wr_done) begin
      busy_ff     <= 1'b0;
    end else if (busy_ff) begin
      prog_cnt_ff <= prog_cnt_ff + 32'h1;
    end
  end

  // ==========================================================
  // write enable latch; set wins over a clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      latch_ff <= SEP_RST_LATCH;
    end else if (set_go) begin
      latch_ff <= 1'b1; // R03
    end else if (clr_go || wr_done) begin
      latch_ff <= 1'b0; // R04
    end
  end

  // ==========================================================
  // lock and protect bits, updated only when the write ends
  logic       pend_ff;      // a status update is pending
  logic       pend_lock_ff; // pending lock value
  logic [1:0] pend_bp_ff;   // pending protect value

  // other bits of the data byte are dropped on purpose
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lock_ff      <= SEP_RST_LOCK;
      bp_ff        <= SEP_RST_BP;
      pend_ff      <= 1'b0;
      pend_lock_ff <= SEP_RST_LOCK;
      pend_bp_ff   <= SEP_RST_BP;
    end else if (stat_go) begin
      pend_ff      <= 1'b1; // R14
      pend_lock_ff <= wr_data_ff[SEP_BIT_LOCK]; // R18
      pend_bp_ff   <= {wr_data_ff[SEP_BIT_BPH], wr_data_ff[SEP_BIT_BPL]};
    end else if (wr_done) begin
      pend_ff <= 1'b0;
      if (pend_ff) begin
        lock_ff <= pend_lock_ff; // R17
        bp_ff   <= pend_bp_ff; // R11
      end
    end
  end

  assign status_byte = '{lock: lock_ff, zero: 3'h0, bp: bp_ff,
                         latch: latch_ff, busy: busy_ff}; // R18

  // ==========================================================
  // status shift-out
  logic [7:0] sh_out_ff;  // remaining bits of the byte
  logic [2:0] out_cnt_ff; // bit position of the byte

  // each byte is a fresh snapshot, so polling sees busy drop
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      spi_miso   <= 1'b0;
      sh_out_ff  <= 8'h00;
      out_cnt_ff <= 3'h0;
    end else if (state_ff != ST_STAT_OUT) begin
      spi_miso   <= 1'b0;
      out_cnt_ff <= 3'h0;
    end else if (sclk_fall) begin // R26
      out_cnt_ff <= out_cnt_ff + 3'h1;
      if (out_cnt_ff == 3'h0) begin
        spi_miso  <= status_byte[7]; // R07
        sh_out_ff <= {status_byte[6:0], 1'b0};
      end else begin
        spi_miso  <= sh_out_ff[7];
        sh_out_ff <= {sh_out_ff[6:0], 1'b0};
      end
    end
  end

  assign spi_miso_oe = state_ff == ST_STAT_OUT;

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  AST_SET_LATCH: assert property (set_go |=> latch_ff) // R03
    else $error("set-latch did not set the latch");
  AST_CLR_LATCH: assert property (clr_go && !set_go |=> !latch_ff) // R05
    else $error("clear-latch did not clear the latch");
  AST_LATCH_END: assert property ($fell(busy_ff) |-> !latch_ff) // R04
    else $error("latch still set after write end");
  AST_NO_LATCH: assert property (stat_try && !latch_ff // R10
    && !busy_ff |=> !busy_ff)
    else $error("status write ran without latch");
  // an array write may start in this cycle, so watch the pending flag
  AST_HW_REJ: assert property (stat_try && hw_mode // R12
    && !busy_ff |=> !pend_ff)
    else $error("status write ran in hardware mode");
  AST_BUSY: assert property (stat_go |=> busy_ff ##1 busy_ff) // R16
    else $error("busy not held after status write start");
  AST_HOLD: assert property (busy_ff && !wr_done // R17
    |=> $stable(lock_ff) && $stable(bp_ff))
    else $error("protect bits moved during write");
  AST_ZERO: assert property (spi_miso_oe && sclk_fall // R18
    && out_cnt_ff == 3'h1 |=> !spi_miso)
    else $error("bit six not zero on the wire");
  AST_FIRST: assert property (spi_miso_oe && sclk_fall // R07
    && out_cnt_ff == 3'h0 |=> spi_miso == $past(lock_ff))
    else $error("status byte did not open with lock bit");
  AST_REGION: assert property (bp_ff == 2'b01 && array_wr_req // R25
    && array_wr_addr >= SEP_QTR_BASE |-> !array_wr_accept)
    else $error("array write accepted in protected quarter");

  CVR_SET: cover property (set_go);
  CVR_STAT_WR: cover property (stat_go ##1 busy_ff);
  CVR_POLL: cover property (spi_miso_oe && busy_ff);
  CVR_HW: cover property (stat_try && hw_mode);

endmodule
`default_nettype wire

// [dv/sep_spi_host.sv]
// sep_spi_host: behavioural spi master in front of the status logic
// assumes: paced by core_clk, 21 core cycles make one 84 ns sclk period
`timescale 1ns/1ps
`default_nettype none
module sep_spi_host (
  input  wire logic core_clk,
  input  wire logic spi_miso,
  output var logic  spi_sclk,
  output var logic  spi_cs_n,
  output var logic  spi_mosi
);
  // ======================================
  // idle: sclk parked low outside frames
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end

  // ======================================
  // one bit: data set while low, taken on the rise
  task automatic put_bit(input logic b, output logic r);
    @(posedge core_clk) spi_mosi <= b;
    repeat (10) @(posedge core_clk);
    spi_sclk <= 1'b1;
    r = spi_miso;
    repeat (10) @(posedge core_clk);
    spi_sclk <= 1'b0;
  endtask

  // whole byte, msb first; answer bits gathered alongside
  task automatic put_byte(input logic [7:0] b, output logic [7:0] r);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i], s);
      r[i] = s;
    end
  endtask

  // select, then half a period before the first bit
  task automatic sel();
    @(posedge core_clk) spi_cs_n <= 1'b0;
    repeat (10) @(posedge core_clk);
  endtask

  // release after the last rise, well before any next rise
  task automatic desel();
    repeat (10) @(posedge core_clk);
    spi_cs_n <= 1'b1;
    spi_mosi <= ~spi_mosi; // stale data must not look valid
    repeat (8) @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

// [dv/spi_eeprom_status_protection_tb.sv]
// spi_eeprom_status_protection_tb: status/protection command checks
// assumes: sep_pkg, the design and sep_spi_host are compiled first
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_status_protection_tb;
  import sep_pkg::*;
  // ======================================
  // short self-timed write keeps the run small
  localparam int unsigned WR_CYC = 400;
  localparam logic [18:0] ADR [6] = '{19'h00000, 19'h3ffff, 19'h40000,
                                      19'h5ffff, 19'h60000, 19'h7ffff};
  logic        core_clk, sys_rst, wp_n, array_wr_req;
  logic        spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
  logic [18:0] array_wr_addr;
  logic        array_wr_accept, addr_protected_ff;
  sep_status_t status_byte;
  logic [7:0]  r;
  int          n, mismatches, comparisons;

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  sep_status_ctrl #(.WRITE_CYCLES(WR_CYC)) u_sep_status_ctrl (
    .core_clk(core_clk), .sys_rst(sys_rst), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .wp_n(wp_n),
    .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
    .array_wr_req(array_wr_req), .array_wr_addr(array_wr_addr),
    .array_wr_accept(array_wr_accept),
    .addr_protected_ff(addr_protected_ff), .status_byte(status_byte));

  sep_spi_host u_sep_spi_host (
    .core_clk(core_clk), .spi_miso(spi_miso), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi));

  // ======================================
  // compare and verdict
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    if (mismatches == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // status sampled after the edge's updates have landed
  task automatic chk_st(input logic [7:0] exp);
    @(negedge core_clk);
    chk(status_byte, exp);
  endtask

  // ======================================
  // frames
  task automatic cmd(input logic [7:0] op);
    logic [7:0] d;
    u_sep_spi_host.sel();
    u_sep_spi_host.put_byte(op, d);
    u_sep_spi_host.desel();
  endtask

  task automatic stat_wr(input logic [7:0] v);
    logic [7:0] d;
    u_sep_spi_host.sel();
    u_sep_spi_host.put_byte(SEP_OP_WR_STAT, d);
    u_sep_spi_host.put_byte(v, d);
    u_sep_spi_host.desel();
  endtask

  // status write with a wrong bit count, all ones
  task automatic wr_bits(input int k);
    logic [7:0] d;
    logic       s;
    u_sep_spi_host.sel();
    u_sep_spi_host.put_byte(SEP_OP_WR_STAT, d);
    for (int i = 0; i < k; i++) u_sep_spi_host.put_bit(1'b1, s);
    u_sep_spi_host.desel();
  endtask

  // bounded wait for the busy flag to drop
  task automatic wait_idle();
    int k;
    k = 0;
    while (status_byte.busy !== 1'b0 && k < 2000) begin
      @(negedge core_clk);
      k++;
    end
    if (k == 2000) begin
      mismatches++;
      $display("[ERR] %0t busy never dropped", $time);
      give_verdict();
    end
  endtask

  // protected region per block-protect code
  function automatic logic [7:0] prot(input logic [1:0] bp,
                                      input logic [18:0] a);
    return {7'h00, bp == 2'b11 || (bp == 2'b10 && a >= 19'h40000)
                   || (bp == 2'b01 && a >= 19'h60000)};
  endfunction

  // ======================================
  // main sequence
  initial begin
    sys_rst = 1'b1;
    wp_n = 1'b1;
    array_wr_req = 1'b0;
    array_wr_addr = '0;
    mismatches = 0;
    comparisons = 0;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge core_clk);
    chk_st(8'h00);
    cmd(8'hff); // unknown opcode ignored
    chk_st(8'h00);
    u_sep_spi_host.sel();
    u_sep_spi_host.put_byte(SEP_OP_SET_LATCH, r);
    u_sep_spi_host.put_byte(SEP_OP_CLR_LATCH, r); // trailing, ignored
    u_sep_spi_host.desel();
    chk_st(8'h02);
    u_sep_spi_host.sel();
    u_sep_spi_host.put_byte(SEP_OP_CLR_LATCH, r);
    chk_st(8'h02);
    u_sep_spi_host.desel();
    chk_st(8'h00);
    stat_wr(8'h8c);
    chk_st(8'h00);
    cmd(SEP_OP_SET_LATCH);
    wr_bits(9);
    chk_st(8'h02);
    wr_bits(7);
    chk_st(8'h02);
    // lock set while the pin is already low
    @(posedge core_clk) wp_n <= 1'b0;
    stat_wr(8'hff);
    u_sep_spi_host.sel();
    u_sep_spi_host.put_byte(SEP_OP_RD_STAT, r);
    u_sep_spi_host.put_byte(8'h00, r);
    chk(r, 8'h03);
    chk({7'h00, spi_miso_oe}, 8'h01);
    n = 0;
    while (r[0] !== 1'b0 && n < 20) begin
      u_sep_spi_host.put_byte(8'h00, r);
      n++;
    end
    u_sep_spi_host.desel();
    // polling ran out of bytes: count it and close the run
    if (r[0] !== 1'b0) begin
      mismatches++;
      $display("[ERR] %0t busy never cleared while polling", $time);
      give_verdict();
    end
    chk(r, 8'h8c);
    chk({7'h00, spi_miso_oe}, 8'h00);
    cmd(SEP_OP_SET_LATCH);
    stat_wr(8'h00); // refused in hardware mode
    chk_st(8'h8e);
    @(posedge core_clk) wp_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    stat_wr(8'h80);
    wait_idle();
    chk_st(8'h80);
    // every protect code against region edges
    for (int bp = 0; bp < 4; bp++) begin
      cmd(SEP_OP_SET_LATCH);
      stat_wr(8'(bp << 2));
      wait_idle();
      chk_st(8'(bp << 2));
      foreach (ADR[k]) begin
        @(posedge core_clk) array_wr_addr <= ADR[k];
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        chk({7'h00, addr_protected_ff}, prot(2'(bp), ADR[k]));
      end
    end
    cmd(SEP_OP_SET_LATCH);
    stat_wr(8'h04);
    wait_idle();
    cmd(SEP_OP_SET_LATCH);
    @(posedge core_clk) array_wr_addr <= 19'h60000;
    array_wr_req <= 1'b1;
    @(negedge core_clk);
    chk({7'h00, array_wr_accept}, 8'h00);
    @(posedge core_clk) array_wr_addr <= 19'h5ffff;
    @(negedge core_clk);
    chk({7'h00, array_wr_accept}, 8'h01);
    @(posedge core_clk) array_wr_req <= 1'b0;
    chk_st(8'h07);
    wait_idle();
    chk_st(8'h04);
    give_verdict();
  end
endmodule
`default_nettype wire
